//--- rtl/sps_map.svh
/*
 * Offsets, field positions, reset values, mode codes and timing counts
 * of the SPI-mode serial port. Assumes inclusion by bare name.
 */
// Summary of operation
// RL1 - Buffer write while shifting sets write collision
// RL2 - Slave byte into full buffer sets overflow
// RL3 - Master role never sets receive overflow
// RL4 - Software reads buffer after every received byte
// RL5 - Enable bit hands pins to the port
// RL6 - Polarity bit sets idle clock level
// RL7 - Mode codes 0-3 select master clock rate
// RL8 - Codes 4/5 select slave, select honoured/ignored
// RL9 - Other mode codes are not SPI operation
// RL10 - Master sleep freezes transfer, resumes after wake
// RL11 - Slave shifts during sleep, flags after 8
// RL12 - Reset disables port and aborts transfer
// RL13 - SPI modes map to polarity and edge
// RL14 - Sample-phase bit picks data sampling point
// RL15 - Master transfer starts only on buffer write
// RL16 - Eight bits, MSB first, both directions; with edge select 0 and late sampling the master buffer misses its last bit
`ifndef SPS_MAP_SVH
`define SPS_MAP_SVH
`define SPS_OFF_CTRL 8'h00
`define SPS_OFF_STAT 8'h04
`define SPS_OFF_BUF 8'h08
`define SPS_OFF_INTS 8'h0C
`define SPS_OFF_INTM 8'h10
`define SPS_CTRL_WRITE_COLLISION_FLAG 7
`define SPS_CTRL_OV 6
`define SPS_CTRL_EN 5
`define SPS_CTRL_CKP 4
`define SPS_STAT_SMP 7
`define SPS_STAT_CKE 6
`define SPS_STAT_BF 0
`define SPS_INT_DONE 0
`define SPS_INT_WRITE_COLLISION_FLAG 1
`define SPS_INT_OV 2
`define SPS_CTRL_RST 8'h00
`define SPS_STAT_RST 8'h00
`define SPS_MODE_DIV4 4'h0
`define SPS_MODE_DIV16 4'h1
`define SPS_MODE_DIV64 4'h2
`define SPS_MODE_TIMER_TWO 4'h3
`define SPS_MODE_SLV_SS 4'h4
`define SPS_MODE_SLV_NOSS 4'h5
`define SPS_HALF_DIV4 6'h02
`define SPS_HALF_DIV16 6'h08
`define SPS_HALF_DIV64 6'h20
`define SPS_EDGE_LAST 5'h10
`define SPS_EDGE_END 5'h11
`define SPS_BIT_LAST 3'h7
`define SPS_RESP_OKAY 2'h0
`define SPS_RESP_SLVERR 2'h2
`endif

//--- rtl/sps_pkg.sv
/*
 * Types of the SPI-mode serial port.
 * Assumes nothing of its surroundings.
 */
package sps_pkg;
	typedef enum logic [0:0] {S_IDLE, S_MASTER} sps_state_t;
endpackage

//--- rtl/sps_top.sv
/*
 * SPI-mode serial port with AXI4-Lite register slave and interrupt.
 * Assumes sleep_in and timer_two_tick come from logic on clk; serial
 * pins are asynchronous and are synchronised here.
 */
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sps_map.svh"
module sps_top import sps_pkg::*; #(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic timer_two_tick,
	input wire logic sleep_in,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	output logic sdo_out,
	output logic sdo_oe,
	input wire logic sdi_in,
	input wire logic ss_n_in,
	output logic irq
);
	logic [7:0] ctrl_reg;
	logic smp_reg, cke_reg, bf_reg;
	logic [7:0] buf_reg;
	logic [7:0] tx_reg;
	logic [7:0] shift_register_reg;
	logic [2:0] bitcnt_reg;
	logic [4:0] hp_reg;
	logic [5:0] div_reg;
	sps_state_t state_reg;
	logic sck_s1_reg, sck_s2_reg, sck_s3_reg;
	logic sdi_s1_reg, sdi_s2_reg;
	logic ss_s1_reg, ss_s2_reg;
	logic [2:0] ints_reg, intm_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [7:0] wdata_reg;
	logic wstrb_reg;

	logic [3:0] mode;
	logic en, clock_idle_polarity, is_master, is_slave, ss_act, busy;
	logic wr_go, wr_ctrl, wr_stat, wr_buf, wr_ints, wr_intm, wr_ok;
	logic rd_go, rd_buf;
	logic write_collision_flag_ev, ov_ev, do_load, done, m_done, s_done;
	logic tick, m_adv, m_in, m_samp, m_out;
	logic [4:0] k;
	logic s_edge, s_lead, s_in, s_out;
	logic [5:0] half;
	logic [7:0] rd_val;
	logic rd_ok;
	logic [1:0] m_samp_reg, m_done_reg;

	assign mode = ctrl_reg[3:0];
	assign en = ctrl_reg[`SPS_CTRL_EN];
	assign clock_idle_polarity = ctrl_reg[`SPS_CTRL_CKP];
	// Reserved and two-wire codes leave the port inert
	assign is_master = en && (mode <= `SPS_MODE_TIMER_TWO); // [RL5] [RL7] [RL9]
	assign is_slave = en && (mode == `SPS_MODE_SLV_SS || mode == `SPS_MODE_SLV_NOSS); // [RL8] [RL9]
	assign ss_act = (mode == `SPS_MODE_SLV_NOSS) || !ss_s2_reg; // [RL8]
	assign busy = (state_reg == S_MASTER) || (is_slave && bitcnt_reg != 3'h0);

	// Register bus decode
	assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wr_ctrl = wr_go && wstrb_reg && awaddr_reg == `SPS_OFF_CTRL;
	assign wr_stat = wr_go && wstrb_reg && awaddr_reg == `SPS_OFF_STAT;
	assign wr_buf = wr_go && wstrb_reg && awaddr_reg == `SPS_OFF_BUF;
	assign wr_ints = wr_go && wstrb_reg && awaddr_reg == `SPS_OFF_INTS;
	assign wr_intm = wr_go && wstrb_reg && awaddr_reg == `SPS_OFF_INTM;
	assign wr_ok = awaddr_reg == `SPS_OFF_CTRL || awaddr_reg == `SPS_OFF_STAT || awaddr_reg == `SPS_OFF_BUF
		|| awaddr_reg == `SPS_OFF_INTS || awaddr_reg == `SPS_OFF_INTM;
	assign rd_go = s_axi_arvalid && s_axi_arready;
	assign rd_buf = rd_go && s_axi_araddr == `SPS_OFF_BUF;

	assign write_collision_flag_ev = wr_buf && busy; // [RL1]
	assign do_load = wr_buf && !busy && (is_master || is_slave);

	// Master bit clock
	always_comb begin
		case (mode)
			`SPS_MODE_DIV16: half = `SPS_HALF_DIV16;
			`SPS_MODE_DIV64: half = `SPS_HALF_DIV64;
			default: half = `SPS_HALF_DIV4;
		endcase
	end
	assign tick = (mode == `SPS_MODE_TIMER_TWO) ? timer_two_tick : (div_reg == half - 6'h01); // [RL7]
	assign m_adv = state_reg == S_MASTER && !sleep_in && tick; // [RL10]
	assign k = hp_reg + 5'h01;
	assign m_in = cke_reg ? k[0] : !k[0]; // [RL13]
	// Late sampling lands on the following edge, or with edge select 0 on the end tick for the last bit
	assign m_samp = m_adv && (smp_reg ? (!m_in && k >= 5'h02) : (m_in && k <= `SPS_EDGE_LAST)); // [RL14]
	assign m_out = m_adv && !m_in && k <= `SPS_EDGE_LAST;
	assign m_done = m_adv && k == `SPS_EDGE_END;

	// Slave edges from the synchronised pin clock
	assign s_edge = is_slave && ss_act && (sck_s2_reg != sck_s3_reg);
	assign s_lead = sck_s3_reg == clock_idle_polarity;
	assign s_in = s_edge && (cke_reg ? s_lead : !s_lead); // [RL13]
	assign s_out = s_edge && !(cke_reg ? s_lead : !s_lead);
	assign s_done = s_in && bitcnt_reg == `SPS_BIT_LAST; // [RL11]

	assign done = m_done_reg[1] || s_done;
	assign ov_ev = s_done && bf_reg && !rd_buf; // [RL2] [RL3]

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sck_s1_reg <= 1'b0;
			sck_s2_reg <= 1'b0;
			sck_s3_reg <= 1'b0;
			sdi_s1_reg <= 1'b0;
			sdi_s2_reg <= 1'b0;
			ss_s1_reg <= 1'b1;
			ss_s2_reg <= 1'b1;
		end else begin
			sck_s1_reg <= sck_in;
			sck_s2_reg <= sck_s1_reg;
			sck_s3_reg <= sck_s2_reg;
			sdi_s1_reg <= sdi_in;
			sdi_s2_reg <= sdi_s1_reg;
			ss_s1_reg <= ss_n_in;
			ss_s2_reg <= ss_s1_reg;
		end
	end

	// AXI4-Lite handshakes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SPS_RESP_OKAY;
			awaddr_reg <= '0;
			wdata_reg <= 8'h00;
			wstrb_reg <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wdata_reg <= s_axi_wdata[7:0];
				wstrb_reg <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `SPS_RESP_OKAY : `SPS_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_comb begin
		rd_ok = 1'b1;
		case (s_axi_araddr)
			`SPS_OFF_CTRL: rd_val = ctrl_reg;
			`SPS_OFF_STAT: rd_val = {smp_reg, cke_reg, 5'h00, bf_reg};
			`SPS_OFF_BUF: rd_val = buf_reg;
			`SPS_OFF_INTS: rd_val = {5'h00, ints_reg};
			`SPS_OFF_INTM: rd_val = {5'h00, intm_reg};
			default: begin
				rd_val = 8'h00;
				rd_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `SPS_RESP_OKAY;
		end else if (rd_go) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_val};
			s_axi_rresp <= rd_ok ? `SPS_RESP_OKAY : `SPS_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Control and status; hardware set wins over a software write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= `SPS_CTRL_RST; // [RL12]
			smp_reg <= 1'b0;
			cke_reg <= 1'b0;
		end else begin
			ctrl_reg[`SPS_CTRL_WRITE_COLLISION_FLAG] <= write_collision_flag_ev || (wr_ctrl ? wdata_reg[`SPS_CTRL_WRITE_COLLISION_FLAG] : ctrl_reg[`SPS_CTRL_WRITE_COLLISION_FLAG]); // [RL1]
			ctrl_reg[`SPS_CTRL_OV] <= ov_ev || (wr_ctrl ? wdata_reg[`SPS_CTRL_OV] : ctrl_reg[`SPS_CTRL_OV]); // [RL2]
			if (wr_ctrl) begin
				ctrl_reg[5:0] <= wdata_reg[5:0];
			end
			if (wr_stat) begin
				smp_reg <= wdata_reg[`SPS_STAT_SMP];
				cke_reg <= wdata_reg[`SPS_STAT_CKE];
			end
		end
	end

	// Receive buffer; an overflowing byte is dropped
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			buf_reg <= 8'h00;
			bf_reg <= 1'b0;
		end else if (done && !ov_ev) begin
			// Slave byte ends on its last sampling edge, so that bit is taken straight in
			buf_reg <= s_done ? {shift_register_reg[6:0], sdi_s2_reg} : shift_register_reg; // [RL16]
			bf_reg <= 1'b1;
		end else if (rd_buf) begin
			bf_reg <= 1'b0; // [RL4]
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= S_IDLE;
			hp_reg <= 5'h00;
			div_reg <= 6'h00;
		end else if (!is_master) begin
			state_reg <= S_IDLE; // [RL5] [RL9] [RL12]
			hp_reg <= 5'h00;
			div_reg <= 6'h00;
		end else if (state_reg == S_IDLE) begin
			hp_reg <= 5'h00;
			div_reg <= 6'h00;
			if (do_load) begin
				state_reg <= S_MASTER; // [RL15]
			end
		end else if (!sleep_in) begin
			div_reg <= tick ? 6'h00 : div_reg + 6'h01;
			if (m_adv) begin
				hp_reg <= k;
			end
			if (m_done) begin
				state_reg <= S_IDLE;
			end
		end
	end

	// Shift paths, MSB first
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_reg <= 8'h00;
			sdo_out <= 1'b0;
		end else if (do_load) begin
			if (cke_reg) begin
				sdo_out <= wdata_reg[7]; // [RL13]
				tx_reg <= {wdata_reg[6:0], 1'b0};
			end else begin
				tx_reg <= wdata_reg;
			end
		end else if (m_out || s_out) begin
			sdo_out <= tx_reg[7]; // [RL16]
			tx_reg <= {tx_reg[6:0], 1'b0};
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shift_register_reg <= 8'h00;
			bitcnt_reg <= 3'h0;
			m_samp_reg <= 2'h0;
			m_done_reg <= 2'h0;
		end else begin
			// Master samples wait out the pin synchroniser; fast rates would see a stale bit
			m_samp_reg <= {m_samp_reg[0], m_samp}; // [RL14]
			m_done_reg <= {m_done_reg[0], m_done};
			if (m_samp_reg[1] || s_in) begin
				shift_register_reg <= {shift_register_reg[6:0], sdi_s2_reg}; // [RL16] [RL11]
			end
			if (!is_slave || !ss_act) begin
				bitcnt_reg <= 3'h0;
			end else if (s_in) begin
				bitcnt_reg <= bitcnt_reg + 3'h1;
			end
		end
	end

	// Pin drive
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sck_out <= 1'b0;
			sck_oe <= 1'b0;
			sdo_oe <= 1'b0;
		end else begin
			sck_oe <= is_master; // [RL5]
			sdo_oe <= is_master || (is_slave && ss_act); // [RL5] [RL8]
			if (state_reg == S_IDLE) begin
				sck_out <= clock_idle_polarity; // [RL6]
			end else if (m_adv && k <= `SPS_EDGE_LAST) begin
				sck_out <= !sck_out;
			end
		end
	end

	// Interrupt status, write one to clear, set wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ints_reg <= 3'h0;
			intm_reg <= 3'h0;
			irq <= 1'b0;
		end else begin
			ints_reg[`SPS_INT_DONE] <= done || (ints_reg[`SPS_INT_DONE] && !(wr_ints && wdata_reg[`SPS_INT_DONE])); // [RL11]
			ints_reg[`SPS_INT_WRITE_COLLISION_FLAG] <= write_collision_flag_ev || (ints_reg[`SPS_INT_WRITE_COLLISION_FLAG] && !(wr_ints && wdata_reg[`SPS_INT_WRITE_COLLISION_FLAG]));
			ints_reg[`SPS_INT_OV] <= ov_ev || (ints_reg[`SPS_INT_OV] && !(wr_ints && wdata_reg[`SPS_INT_OV]));
			if (wr_intm) begin
				intm_reg <= wdata_reg[2:0];
			end
			irq <= |(ints_reg & intm_reg);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_write_collision_flag_set;
		write_collision_flag_ev |=> ctrl_reg[`SPS_CTRL_WRITE_COLLISION_FLAG];
	endproperty
	a_write_collision_flag_set: assert property (p_write_collision_flag_set) else $error("collision flag not set"); // [RL1]

	property p_ov_keep;
		ov_ev |=> ctrl_reg[`SPS_CTRL_OV] && buf_reg == $past(buf_reg);
	endproperty
	a_ov_keep: assert property (p_ov_keep) else $error("overflow flag or buffer wrong"); // [RL2]

	property p_master_no_ov;
		(state_reg == S_MASTER) |-> !ov_ev;
	endproperty
	a_master_no_ov: assert property (p_master_no_ov) else $error("overflow in master role"); // [RL3]

	property p_pins_off;
		!ctrl_reg[`SPS_CTRL_EN] |=> !sck_oe && !sdo_oe;
	endproperty
	a_pins_off: assert property (p_pins_off) else $error("pins driven while disabled"); // [RL5]

	property p_idle_pol;
		(state_reg == S_IDLE) |=> sck_out == $past(ctrl_reg[`SPS_CTRL_CKP]);
	endproperty
	a_idle_pol: assert property (p_idle_pol) else $error("idle clock level wrong"); // [RL6]

	property p_div4;
		(m_adv && mode == `SPS_MODE_DIV4 && k < `SPS_EDGE_END && !wr_ctrl) |=> !m_adv ##1 (m_adv || sleep_in || wr_ctrl);
	endproperty
	a_div4: assert property (p_div4) else $error("fosc/4 half period wrong"); // [RL7]

	property p_reserved;
		(mode > `SPS_MODE_SLV_NOSS) |=> state_reg == S_IDLE && !sck_oe;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved mode active"); // [RL9]

	property p_sleep_freeze;
		(state_reg == S_MASTER && sleep_in && is_master) |=> $stable(hp_reg) && $stable(sck_out);
	endproperty
	a_sleep_freeze: assert property (p_sleep_freeze) else $error("master moved during sleep"); // [RL10]

	property p_slave_done;
		s_done |=> ints_reg[`SPS_INT_DONE];
	endproperty
	a_slave_done: assert property (p_slave_done) else $error("byte flag not set"); // [RL11]

	property p_start;
		$rose(state_reg == S_MASTER) |-> $past(do_load);
	endproperty
	a_start: assert property (p_start) else $error("master start without write"); // [RL15]

	sequence s_mstart;
		do_load && is_master;
	endsequence
	sequence s_mrun;
		(state_reg == S_MASTER) [*8];
	endsequence
	property p_len;
		s_mstart |=> s_mrun;
	endproperty
	a_len: assert property (p_len) else $error("master transfer too short"); // [RL16]
endmodule // sps_top
`default_nettype wire

//--- testbench/sps_peer.sv
/*
 * SPI peer on the serial pins: slave to the port in master role,
 * master to it in slave role.
 * Assumes edge select 1 and idle-low clock.
 */
`timescale 1ns/1ps
`default_nettype none
module sps_peer (
	input wire logic clk,
	input wire logic sck_out,
	input wire logic sck_oe,
	input wire logic sdo_out,
	output logic sck_in,
	output logic ss_n_in,
	output logic sdi_in
);
	logic [7:0] tx_reg = 8'h00;
	logic [7:0] rx_reg = 8'h00;
	initial begin
		sck_in = 1'b0;
		ss_n_in = 1'b1;
	end
	// Sample on the leading edge, shift on the trailing edge
	always @(posedge sck_out) if (sck_oe) rx_reg <= {rx_reg[6:0], sdo_out};
	always @(negedge sck_out) if (sck_oe) tx_reg <= {tx_reg[6:0], ~tx_reg[7]};
	always @(posedge sck_in) if (!ss_n_in) rx_reg <= {rx_reg[6:0], sdo_out};
	// Idle shifts keep changing the line so a stale bit never looks valid
	assign sdi_in = tx_reg[7];
	// Clock stands still outside the frame
	task automatic send(input logic [7:0] b, input int half);
		tx_reg <= b;
		ss_n_in <= 1'b0;
		repeat (half) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			sck_in <= 1'b1;
			repeat (half) @(posedge clk);
			sck_in <= 1'b0;
			tx_reg <= {tx_reg[6:0], ~tx_reg[7]};
			repeat (half) @(posedge clk);
		end
		ss_n_in <= 1'b1;
	endtask
endmodule // sps_peer
`default_nettype wire

//--- testbench/sps_top_tb.sv
/*
 * Self-checking bench of the serial port: AXI4-Lite master, byte model.
 * Assumes sps_top and sps_peer are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sps_map.svh"
module sps_top_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic [31:0] wdata = 32'h0, rdata;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp, rsp;
	logic tick = 1'b0, sleep_in = 1'b0;
	logic [1:0] tick_cnt = 2'h0;
	logic sck_in, sck_out, sck_oe, sdo_out, sdo_oe, sdi_in, ss_n_in;
	logic [31:0] d;
	logic [7:0] b, a;
	logic [7:0] q[$];
	int fails = 0, check_count = 0, cyc = 0;
	always #5 clk = ~clk;
	sps_top sps_top_inst (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .timer_two_tick(tick),
		.sleep_in(sleep_in), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .sdo_out(sdo_out),
		.sdo_oe(sdo_oe), .sdi_in(sdi_in), .ss_n_in(ss_n_in), .irq(irq));
	sps_peer sps_peer_inst (.clk(clk), .sck_out(sck_out), .sck_oe(sck_oe), .sdo_out(sdo_out),
		.sck_in(sck_in), .ss_n_in(ss_n_in), .sdi_in(sdi_in));
	always @(posedge clk) begin
		tick_cnt <= tick_cnt + 2'h1;
		tick <= (tick_cnt == 2'h3);
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fails++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// Address and data offered together, each released when taken
	task automatic wr(input logic [7:0] ad, input logic [31:0] v);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		awaddr <= ad;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (aw || w) begin
			@(posedge clk);
			if (aw && awready) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		rsp = bresp;
	endtask
	task automatic rd(input logic [7:0] ad);
		araddr <= ad;
		arvalid <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		d = rdata;
		rsp = rresp;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		void'($urandom(83085));
		@(posedge clk);
		rd(`SPS_OFF_CTRL);
		chk(d, 32'h0);
		chk(sck_oe | sdo_oe, 1'b0);
		rd(8'h14);
		chk(rsp, `SPS_RESP_SLVERR);
		wr(8'h14, 32'hFF);
		chk(rsp, `SPS_RESP_SLVERR);
		wr(`SPS_OFF_STAT, 32'h40);
		wr(`SPS_OFF_INTM, 32'h1);
		chk(rsp, `SPS_RESP_OKAY);
		for (int m = 0; m < 4; m++) begin
			b = 8'($urandom);
			a = 8'($urandom);
			sps_peer_inst.tx_reg <= b;
			q.push_back(b);
			// Odd modes sample at the end of the bit
			wr(`SPS_OFF_STAT, {24'h0, m[0], 7'h40});
			wr(`SPS_OFF_CTRL, 32'h20 | m);
			wr(`SPS_OFF_BUF, {24'h0, a});
			// Second write lands mid-shift and must be refused
			wr(`SPS_OFF_BUF, {24'h0, ~a});
			if (m == 1) begin
				sleep_in <= 1'b1;
				repeat (60) @(posedge clk);
				chk(sck_oe, 1'b1);
				sleep_in <= 1'b0;
			end
			while (irq !== 1'b1) @(posedge clk);
			rd(`SPS_OFF_BUF);
			chk(d, {24'h0, q.pop_front()});
			chk(sps_peer_inst.rx_reg, a);
			rd(`SPS_OFF_CTRL);
			chk(d, 32'hA0 | m);
			chk(sck_out, 1'b0);
			wr(`SPS_OFF_CTRL, 32'h20 | m);
			wr(`SPS_OFF_INTS, 32'h7);
			repeat (2) @(posedge clk);
			chk(irq, 1'b0);
			$display("test master mode %0d done", m);
		end
		wr(`SPS_OFF_CTRL, 32'h26);
		wr(`SPS_OFF_BUF, 32'h5A);
		repeat (100) @(posedge clk);
		chk(sck_oe, 1'b0);
		$display("test reserved mode done");
		wr(`SPS_OFF_CTRL, 32'h24);
		a = 8'($urandom);
		b = 8'($urandom);
		sps_peer_inst.send(a, 20);
		while (irq !== 1'b1) @(posedge clk);
		chk(sck_oe, 1'b0);
		sps_peer_inst.send(b, 20);
		repeat (20) @(posedge clk);
		rd(`SPS_OFF_CTRL);
		chk(d[6], 1'b1);
		chk(sdo_oe, 1'b0);
		rd(`SPS_OFF_BUF);
		chk(d, {24'h0, a});
		$display("test slave overflow done");
		wr(`SPS_OFF_CTRL, 32'h25);
		@(posedge clk);
		chk(sdo_oe, 1'b1);
		wr(`SPS_OFF_INTS, 32'h7);
		a = 8'($urandom);
		b = 8'($urandom);
		wr(`SPS_OFF_BUF, {24'h0, a});
		// Select ignored; the byte must still arrive while the device sleeps
		sleep_in <= 1'b1;
		sps_peer_inst.send(b, 20);
		repeat (5) @(posedge clk);
		chk(irq, 1'b1);
		sleep_in <= 1'b0;
		rd(`SPS_OFF_BUF);
		chk(d, {24'h0, b});
		chk(sps_peer_inst.rx_reg, a);
		$display("test slave without select done");
		wr(`SPS_OFF_CTRL, 32'h22);
		wr(`SPS_OFF_BUF, 32'hA5);
		repeat (40) @(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk(sck_oe | sdo_oe | irq, 1'b0);
		rd(`SPS_OFF_CTRL);
		chk(d, 32'h0);
		rd(`SPS_OFF_INTS);
		chk(d, 32'h0);
		$display("test mid-run reset done");
		test_done();
	end
endmodule // sps_top_tb
`default_nettype wire
